// ===== hdl/mode_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

module mode_register_bank (
    input  wire logic                          CLK,
    input  wire logic                          RST_B,
    input  wire logic                          SCLK,
    input  wire logic                          CS_B,
    input  wire logic                          DIN,
    input  wire logic                          SYNC_B,
    input  wire logic                          RESULT_VALID,
    input  wire logic [23:0]                   RESULT_DATA,
    input  wire logic [3:0]                    RESULT_CHANNEL,
    input  wire logic                          RESULT_ERROR,
    input  wire logic                          UPDATE_SOON,
    input  wire logic                          CORE_HALTED,
    output logic                               DOUT,
    output logic                               DOUT_OE,
    output mode_reg_pkg::mode_fields_type      MODE_CTRL,
    output mode_reg_pkg::clock_route_type      CLOCK_ROUTE,
    output logic                               MODULATOR_RESET,
    output logic                               NOT_READY
);

    logic [3:0]                     pins_synced;
    logic                           sclk_s;
    logic                           cs_b_s;
    logic                           din_s;
    logic                           sync_b_s;
    logic                           sclk_prev;
    logic                           sclk_rise;
    logic                           sclk_fall;
    mode_reg_pkg::serial_state_type state;
    logic [4:0]                     bit_count;
    logic [4:0]                     last_index;
    logic [31:0]                    rx_shift;
    logic [31:0]                    tx_shift;
    logic                           reading_data;
    logic [23:0]                    data_word;
    logic [3:0]                     data_channel;
    logic                           data_error;
    logic                           data_parity;
    logic [7:0]                     status_byte;
    logic [7:0]                     next_command;
    logic [23:0]                    next_word;
    logic                           word_done;
    logic                           mode_write;
    logic                           data_read_done;
    logic [2:0]                     sel;

    pin_sync #(
        .WIDTH       (4),
        .RESET_LEVEL (4'hF)
    ) u_pin_sync (
        .CLK         (CLK),
        .RST_B       (RST_B),
        .PIN_IN      ({SCLK, CS_B, DIN, SYNC_B}),
        .PIN_OUT     (pins_synced)
    );

    assign sclk_s   = pins_synced[3];
    assign cs_b_s   = pins_synced[2];
    assign din_s    = pins_synced[1];
    assign sync_b_s = pins_synced[0];

    // clock idles high: sample on rising edge, shift out on falling edge
    assign sclk_rise = sclk_s & ~sclk_prev;
    assign sclk_fall = ~sclk_s & sclk_prev;

    assign next_command   = {rx_shift[6:0], din_s};
    assign next_word      = {rx_shift[22:0], din_s};
    assign word_done      = sclk_rise && (bit_count == last_index);
    assign sel            = next_command[mode_reg_pkg::CMD_SEL_HI:mode_reg_pkg::CMD_SEL_LO];
    assign mode_write     = !cs_b_s && (state == mode_reg_pkg::ST_WRITE) && word_done;
    assign data_read_done = !cs_b_s && (state == mode_reg_pkg::ST_READ) && word_done
                            && reading_data;
    assign status_byte    = {NOT_READY, data_error, 1'b0, data_parity, data_channel};

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sclk_prev <= 1'b1;
        end
        else
        begin
            sclk_prev <= sclk_s;
        end
    end

    // command byte, then a register transfer; raising chip select restarts framing
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state        <= mode_reg_pkg::ST_COMMAND;
            bit_count    <= mode_reg_pkg::COUNT_ZERO;
            last_index   <= mode_reg_pkg::LAST_BYTE;
            rx_shift     <= 32'h00000000;
            tx_shift     <= 32'h00000000;
            reading_data <= 1'b0;
        end
        else if (cs_b_s)
        begin
            state        <= mode_reg_pkg::ST_COMMAND;
            bit_count    <= mode_reg_pkg::COUNT_ZERO;
            last_index   <= mode_reg_pkg::LAST_BYTE;
            reading_data <= 1'b0;
        end
        else
        begin
            if (sclk_fall && state == mode_reg_pkg::ST_READ)
            begin
                tx_shift <= {tx_shift[30:0], 1'b0};
            end
            if (sclk_rise)
            begin
                rx_shift  <= {rx_shift[30:0], din_s};
                bit_count <= word_done ? mode_reg_pkg::COUNT_ZERO
                                       : bit_count + mode_reg_pkg::COUNT_ONE;
            end
            unique case (state)
                mode_reg_pkg::ST_COMMAND:
                begin
                    if (word_done && !next_command[mode_reg_pkg::CMD_WRITE_EN_BIT])
                    begin
                        if (next_command[mode_reg_pkg::CMD_READ_BIT])
                        begin
                            reading_data <= (sel == mode_reg_pkg::SEL_DATA);
                            if (sel == mode_reg_pkg::SEL_MODE)
                            begin
                                state      <= mode_reg_pkg::ST_READ;
                                tx_shift   <= {MODE_CTRL, mode_reg_pkg::ZERO_BYTE};
                                last_index <= mode_reg_pkg::LAST_WORD;
                            end
                            else if (sel == mode_reg_pkg::SEL_STATUS)
                            begin
                                state      <= mode_reg_pkg::ST_READ;
                                tx_shift   <= {status_byte, mode_reg_pkg::ZERO_WORD};
                                last_index <= mode_reg_pkg::LAST_BYTE;
                            end
                            else if (sel == mode_reg_pkg::SEL_DATA)
                            begin
                                state <= mode_reg_pkg::ST_READ;
                                if (MODE_CTRL.append_status_on_read)
                                begin
                                    tx_shift   <= {data_word, status_byte};
                                    last_index <= mode_reg_pkg::LAST_WORD_STATUS;
                                end
                                else
                                begin
                                    tx_shift   <= {data_word, mode_reg_pkg::ZERO_BYTE};
                                    last_index <= mode_reg_pkg::LAST_WORD;
                                end
                            end
                        end
                        else if (sel == mode_reg_pkg::SEL_MODE)
                        begin
                            state      <= mode_reg_pkg::ST_WRITE;
                            last_index <= mode_reg_pkg::LAST_WORD;
                        end
                    end
                end
                mode_reg_pkg::ST_WRITE, mode_reg_pkg::ST_READ:
                begin
                    if (word_done)
                    begin
                        state        <= mode_reg_pkg::ST_COMMAND;
                        last_index   <= mode_reg_pkg::LAST_BYTE;
                        reading_data <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MODE_CTRL <= mode_reg_pkg::MODE_RESET;
        end
        else if (mode_write)
        begin
            MODE_CTRL               <= next_word;
            // bit 14 kept at zero even if the host breaks convention
            MODE_CTRL.reserved_zero <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MODULATOR_RESET <= 1'b0;
        end
        else
        begin
            MODULATOR_RESET <= mode_write;
        end
    end

    // registered decode lags the mode register by one cycle
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CLOCK_ROUTE <= 4'h2;
        end
        else
        begin
            CLOCK_ROUTE.use_crystal  <= ({MODE_CTRL.clock_src_hi, MODE_CTRL.clock_src_lo}
                                         == mode_reg_pkg::CLK_CRYSTAL);
            CLOCK_ROUTE.use_external <= ({MODE_CTRL.clock_src_hi, MODE_CTRL.clock_src_lo}
                                         == mode_reg_pkg::CLK_EXTERNAL);
            CLOCK_ROUTE.use_internal <= MODE_CTRL.clock_src_hi;
            CLOCK_ROUTE.pin_b_drive  <= ({MODE_CTRL.clock_src_hi, MODE_CTRL.clock_src_lo}
                                         == mode_reg_pkg::CLK_INT_DRIVE);
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            data_word    <= 24'h000000;
            data_channel <= 4'h0;
            data_error   <= 1'b0;
            data_parity  <= 1'b0;
        end
        else if (RESULT_VALID)
        begin
            data_word    <= RESULT_DATA;
            data_channel <= RESULT_CHANNEL;
            data_error   <= RESULT_ERROR;
            data_parity  <= MODE_CTRL.parity_enable & (^RESULT_DATA);
        end
    end

    // set terms win over a result arriving in the same cycle
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            NOT_READY <= 1'b1;
        end
        else if (mode_write || data_read_done || UPDATE_SOON || CORE_HALTED || !sync_b_s)
        begin
            NOT_READY <= 1'b1;
        end
        else if (RESULT_VALID)
        begin
            NOT_READY <= 1'b0;
        end
    end

    // outside a read the data pin mirrors not-ready
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            DOUT    <= 1'b1;
            DOUT_OE <= 1'b0;
        end
        else
        begin
            DOUT_OE <= !cs_b_s;
            if (state == mode_reg_pkg::ST_READ && !cs_b_s)
            begin
                if (sclk_fall)
                begin
                    DOUT <= tx_shift[31];
                end
            end
            else
            begin
                DOUT <= NOT_READY;
            end
        end
    end

endmodule : mode_register_bank

`default_nettype wire

// ===== hdl/mode_reg_pkg.sv
// Behaviour
// - the host selects the operating-mode register by putting select code 001 in the command byte, and the next transfer moves that register.
// - the operating-mode register is 24 bits wide and the host can both write it and read it back.
// - after reset the operating-mode register holds 0x080060 (internal clock, rate bits 6 and 5 set).
// - every register transfer is shifted most significant bit first, bit 23 down to bit 0 for this register.
// - each write to the operating-mode register resets the modulator and filter and sets the not-ready flag.
// - the register steers the operating mode, the output data rate and the conversion clock source.
// - bits 23 to 21 choose the operating mode of the converter.
// - with bit 20 set, every data read carries the 8-bit status byte, which names the channel, after the data.
// - bits 19 and 18 choose between the on-chip oscillator and an outside clock.
// - clock code 00 is a crystal, 01 an outside clock on pin b, 10 internal with pin b floating, 11 internal driven onto pin b.
// - with parity enabled the status parity bit is set for an odd number of ones in the data word and cleared for an even one.
// - not-ready clears on a new result and sets after a data read, before an update, when halted, or while sync is low.
package mode_reg_pkg;

    typedef struct packed {
        logic [2:0] op_mode_sel;
        logic       append_status_on_read;
        logic       clock_src_hi;
        logic       clock_src_lo;
        logic       averaging_hi;
        logic       averaging_lo;
        logic       third_order_filter_sel;
        logic       reserved_zero;
        logic       parity_enable;
        logic       clock_divide;
        logic       single_cycle;
        logic       sixty_hz_notch;
        logic [9:0] rate_word;
    } mode_fields_type;

    typedef struct packed {
        logic       use_crystal;
        logic       use_external;
        logic       use_internal;
        logic       pin_b_drive;
    } clock_route_type;

    typedef enum logic [2:0] {
        ST_COMMAND = 3'h1,
        ST_WRITE   = 3'h2,
        ST_READ    = 3'h4
    } serial_state_type;

    localparam logic [23:0] MODE_RESET       = 24'h080060;

    localparam logic [2:0]  SEL_STATUS       = 3'h0;
    localparam logic [2:0]  SEL_MODE         = 3'h1;
    localparam logic [2:0]  SEL_DATA         = 3'h3;

    localparam int          CMD_WRITE_EN_BIT = 7;
    localparam int          CMD_READ_BIT     = 6;
    localparam int          CMD_SEL_HI       = 5;
    localparam int          CMD_SEL_LO       = 3;

    localparam logic [1:0]  CLK_CRYSTAL      = 2'h0;
    localparam logic [1:0]  CLK_EXTERNAL     = 2'h1;
    localparam logic [1:0]  CLK_INT_FLOAT    = 2'h2;
    localparam logic [1:0]  CLK_INT_DRIVE    = 2'h3;

    localparam logic [4:0]  LAST_BYTE        = 5'h07;
    localparam logic [4:0]  LAST_WORD        = 5'h17;
    localparam logic [4:0]  LAST_WORD_STATUS = 5'h1F;

    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
    localparam logic [23:0] ZERO_WORD        = 24'h000000;
    localparam logic [4:0]  COUNT_ZERO       = 5'h00;
    localparam logic [4:0]  COUNT_ONE        = 5'h01;

endpackage : mode_reg_pkg

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int               WIDTH       = 4,
    parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
    input  wire logic             CLK,
    input  wire logic             RST_B,
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] PIN_OUT
);

    logic [WIDTH-1:0] first_stage;

    // reset level is a constant at each instance; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always_ff @(posedge CLK or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    first_stage[i] <= RESET_LEVEL[i];
                    PIN_OUT[i]     <= RESET_LEVEL[i];
                end
                else
                begin
                    first_stage[i] <= PIN_IN[i];
                    PIN_OUT[i]     <= first_stage[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ===== test/mode_reg_properties.sv
`timescale 1ns/1ps
`default_nettype none

module mode_reg_properties (
    input wire logic                          CLK,
    input wire logic                          RST_B,
    input wire logic                          CS_B,
    input wire logic                          SYNC_B,
    input wire logic                          RESULT_VALID,
    input wire logic                          UPDATE_SOON,
    input wire logic                          CORE_HALTED,
    input wire mode_reg_pkg::mode_fields_type MODE_CTRL,
    input wire mode_reg_pkg::clock_route_type CLOCK_ROUTE,
    input wire logic                          DOUT_OE,
    input wire logic                          MODULATOR_RESET,
    input wire logic                          NOT_READY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    function automatic logic [3:0] route_of(input logic [1:0] code);
        case (code)
            mode_reg_pkg::CLK_CRYSTAL:   route_of = 4'h8;
            mode_reg_pkg::CLK_EXTERNAL:  route_of = 4'h4;
            mode_reg_pkg::CLK_INT_FLOAT: route_of = 4'h2;
            default:                     route_of = 4'h3;
        endcase
    endfunction : route_of

    // modulator reset is launched on the same edge as the register update
    sequence s_write_follow;
        (NOT_READY && MODULATOR_RESET) ##1 !MODULATOR_RESET;
    endsequence
    // link idle long enough that no read end or write can set the flag too
    sequence s_quiet_result;
        (SYNC_B && CS_B)[*6] ##0 (RESULT_VALID && !UPDATE_SOON && !CORE_HALTED);
    endsequence

    property p_reset_value;
        $rose(RST_B) |-> MODE_CTRL == 24'h080060;
    endproperty
    property p_write_follow;
        $changed(MODE_CTRL) |-> s_write_follow;
    endproperty
    property p_write_cause;
        $changed(MODE_CTRL) |-> !$past(CS_B, 4);
    endproperty
    property p_route;
        CLOCK_ROUTE == route_of($past(MODE_CTRL[19:18]));
    endproperty
    property p_sync;
        (!SYNC_B)[*5] |-> NOT_READY;
    endproperty
    property p_halt;
        CORE_HALTED |=> NOT_READY;
    endproperty
    property p_update;
        UPDATE_SOON |=> NOT_READY;
    endproperty
    property p_clear;
        s_quiet_result |=> !NOT_READY;
    endproperty
    // two synchroniser stages plus the output flop
    property p_pin_drive;
        DOUT_OE == !$past(CS_B, 3);
    endproperty

    a_reset_value: assert property (p_reset_value)
        else $error("mode register not at its reset value");
    a_write_follow: assert property (p_write_follow)
        else $error("mode write without not ready and one modulator reset pulse");
    a_write_cause: assert property (p_write_cause)
        else $error("mode register changed without a selected transfer");
    a_route: assert property (p_route)
        else $error("clock route does not match clock select field");
    a_sync: assert property (p_sync)
        else $error("not ready clear while sync held low");
    a_halt: assert property (p_halt)
        else $error("not ready clear while core halted");
    a_update: assert property (p_update)
        else $error("not ready clear after update warning");
    a_clear: assert property (p_clear)
        else $error("not ready kept after new result");
    a_pin_drive: assert property (p_pin_drive)
        else $error("data pin enable does not follow chip select");
endmodule : mode_reg_properties

bind mode_register_bank mode_reg_properties u_props (
    .CLK, .RST_B, .CS_B, .SYNC_B, .RESULT_VALID, .UPDATE_SOON, .CORE_HALTED,
    .MODE_CTRL, .CLOCK_ROUTE, .DOUT_OE, .MODULATOR_RESET, .NOT_READY
);

`default_nettype wire

// ===== test/host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_serial_model #(
    parameter int HALF = 5
) (
    input  wire logic CLK,
    input  wire logic DOUT,
    output var logic  SCLK,
    output var logic  CS_B,
    output var logic  DIN
);
    initial
    begin
        SCLK = 1'h1;
        CS_B = 1'h1;
        DIN  = 1'h0;
    end

    // each level lasts HALF clocks; the device needs at least four
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            SCLK <= 1'h0;
            DIN  <= tx[i];
            repeat (HALF) @(posedge CLK);
            rx[i] = DOUT;
            SCLK <= 1'h1;
            repeat (HALF) @(posedge CLK);
        end
    endtask : shift

    task automatic access(input logic [7:0] cmd, input logic [31:0] tx, input int n,
                          output logic [31:0] rx);
        logic [31:0] word;
        logic [31:0] unused;
        word = tx;
        if (cmd[5:3] == 3'h1 && !cmd[6])
            word[14] = 1'h0;
        CS_B <= 1'h0;
        repeat (6) @(posedge CLK);
        shift({24'h0, cmd}, 8, unused);
        shift(word, n, rx);
        repeat (8) @(posedge CLK);
        CS_B <= 1'h1;
        // no pull on the line, so it must not keep the last bit
        DIN  <= ~DIN;
        repeat (6) @(posedge CLK);
    endtask : access
endmodule : host_serial_model

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                          clk;
    logic                          rst_b;
    logic                          sclk;
    logic                          cs_b;
    logic                          din;
    logic                          sync_b;
    logic                          res_valid;
    logic [23:0]                   res_data;
    logic [3:0]                    res_chan;
    logic                          res_err;
    logic                          upd;
    logic                          halted;
    logic                          dout;
    mode_reg_pkg::mode_fields_type mode;
    mode_reg_pkg::clock_route_type route;
    logic                          not_ready;
    logic [31:0]                   rx;
    logic [31:0]                   w;
    logic [31:0]                   exp;
    logic [7:0]                    stat;
    int                            n_fail = 0;
    int                            compares = 0;

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    mode_register_bank u_dut (
        .CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .DIN(din), .SYNC_B(sync_b),
        .RESULT_VALID(res_valid), .RESULT_DATA(res_data), .RESULT_CHANNEL(res_chan),
        .RESULT_ERROR(res_err), .UPDATE_SOON(upd), .CORE_HALTED(halted), .DOUT(dout),
        .DOUT_OE(), .MODE_CTRL(mode), .CLOCK_ROUTE(route), .MODULATOR_RESET(),
        .NOT_READY(not_ready)
    );

    host_serial_model u_host (.CLK(clk), .DOUT(dout), .SCLK(sclk), .CS_B(cs_b), .DIN(din));

    function automatic logic [3:0] route_exp(input logic [1:0] code);
        route_exp = (code == 2'h0) ? 4'h8 : (code == 2'h1) ? 4'h4 : {3'h1, code[0]};
    endfunction : route_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        compares++;
        if (seen !== want)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic give_result;
        @(posedge clk);
        res_valid <= 1'h1;
        res_data  <= 24'($urandom);
        res_chan  <= 4'($urandom);
        res_err   <= 1'($urandom);
        @(posedge clk);
        res_valid <= 1'h0;
        repeat (2) @(posedge clk);
        check(not_ready, 1'h0, "ready after result");
        check(dout, 1'h0, "data pin shows ready");
    endtask : give_result

    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial
    begin
        void'($urandom(32'h4495250C));
        rst_b = 1'h0;
        sync_b = 1'h1;
        res_valid = 1'h0;
        res_data = 24'h0;
        res_chan = 4'h0;
        res_err = 1'h0;
        upd = 1'h0;
        halted = 1'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        repeat (6) @(posedge clk);
        u_host.access(8'h48, 32'h0, 24, rx);
        check(rx, 32'h080060, "reset readback");
        check(route, 4'h2, "reset clock route");
        for (int k = 0; k < 4; k++)
        begin
            w = $urandom;
            w[20] = k[0];
            w[13] = k[1];
            w[19:18] = k[1:0];
            exp = {8'h00, w[23:15], 1'h0, w[13:0]};
            u_host.access(8'h08, w, 24, rx);
            check(mode, exp, "mode write");
            check(mode.op_mode_sel, w[23:21], "mode field");
            check(not_ready, 1'h1, "write sets not ready");
            check(route, route_exp(w[19:18]), "clock route");
            u_host.access(8'h48, 32'h0, 24, rx);
            check(rx, exp, "mode readback");
            give_result();
            stat = {1'h0, res_err, 1'h0, k[1] & (^res_data), res_chan};
            u_host.access(8'h40, 32'h0, 8, rx);
            check(rx, {24'h0, stat}, "status byte");
            u_host.access(8'h58, 32'h0, k[0] ? 32 : 24, rx);
            check(rx, k[0] ? {res_data, stat} : {8'h00, res_data}, "data read");
            check(not_ready, 1'h1, "read sets not ready");
            check(dout, 1'h1, "data pin shows not ready");
        end
        exp = {8'h00, mode};
        u_host.access(8'h08, 32'hFFF, 12, rx);
        check(mode, exp, "aborted write");
        u_host.access(8'h88, 32'hFFFFFF, 24, rx);
        check(mode, exp, "write with enable bit set");
        u_host.access(8'h10, 32'hFFFFFF, 24, rx);
        check(mode, exp, "write to other select");
        for (int s = 0; s < 3; s++)
        begin
            give_result();
            upd    <= (s == 0);
            halted <= (s == 1);
            sync_b <= (s != 2);
            repeat (6) @(posedge clk);
            check(not_ready, 1'h1, "not ready set");
            upd    <= 1'h0;
            halted <= 1'h0;
            sync_b <= 1'h1;
            repeat (4) @(posedge clk);
        end
        rst_b <= 1'h0;
        repeat (3) @(posedge clk);
        check(mode, 32'h080060, "mode after reset");
        check(route, 4'h2, "route after reset");
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
